// ===== hw/rdt_pkg.sv
// Shared constants, carriers and helpers of the clock date/time setter.
// Assumes a 200 MHz sys_clk and an APB master with 32-bit data.
//
// Function
// - Date load acts only while enabled
// - Done flag follows operation enable one edge later
// - Day input carries 1 to 31
// - Weekday 1 to 7, 1 is Sunday
// - Date load takes two or four digit year
// - Date load writes fields unchanged, no conversion
// - Local load converts to UTC by offset
// - Local load year is two digits
// - Local load hours 0-23, minutes/seconds 0-59
// - Time load ranges checked, acts when enabled
// - Time load writes fields unchanged
// - Zone offset: signed minutes, loaded when enabled
// - Offset applied on local load and read
// - Zone offset volatile, cleared at reset
package rdt_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DATE_IN = 8'h04;
	localparam logic [7:0] REG_TIME_IN = 8'h08;
	localparam logic [7:0] REG_ZONE_IN = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CLK_DATE = 8'h14;
	localparam logic [7:0] REG_CLK_TIME = 8'h18;
	localparam logic [7:0] REG_LOC_DATE = 8'h1c;
	localparam logic [7:0] REG_LOC_TIME = 8'h20;
	localparam logic [7:0] REG_ZONE = 8'h24;

	// ****************************************************************
	// Control and status bit positions, reset values
	// ****************************************************************
	localparam int OP_DATE = 0;
	localparam int OP_TIME = 1;
	localparam int OP_LOCAL = 2;
	localparam int OP_ZONE = 3;
	localparam int OP_READ = 4;
	localparam int NUM_OPS = 5;
	localparam int STAT_RANGE_ERR = 8;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic signed [15:0] ZONE_RESET = 16'sh0000;
	localparam logic [10:0] MIN_PER_DAY = 11'h5a0;
	localparam logic [10:0] MIN_PER_HOUR = 11'h03c;
	localparam logic [11:0] CENTURY_BASE = 12'h7d0;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [11:0] year;
		logic [2:0] weekday;
		logic [4:0] day;
		logic [3:0] month;
	} rdt_date_t;

	typedef struct packed {
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rdt_time_t;

	localparam rdt_date_t DATE_RESET = '{12'h7d0, 3'h1, 5'h01, 4'h1};
	localparam rdt_time_t TIME_RESET = '{5'h00, 6'h00, 6'h00};

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Date fields inside their documented ranges
	function automatic logic date_ok(input rdt_date_t d);
		date_ok = (d.month >= 4'h1) && (d.month <= 4'hc) &&
			(d.day >= 5'h01) && (d.weekday >= 3'h1) &&
			(d.weekday <= 3'h7);
	endfunction

	// Time fields inside their documented ranges
	function automatic logic time_ok(input rdt_time_t t);
		time_ok = (t.hour <= 5'h17) && (t.minute <= 6'h3b) &&
			(t.second <= 6'h3b);
	endfunction

	// Days in a month, leap every fourth year
	function automatic logic [4:0] month_len(input logic [3:0] m,
		input logic [11:0] y);
		unique case (m)
			4'h2: month_len = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb: month_len = 5'h1e;
			default: month_len = 5'h1f;
		endcase
	endfunction

endpackage

// ===== hw/rdt_zone_conv.sv
// Shifts a date and time by a signed number of minutes.
// Assumes the offset magnitude stays below one day (1440 minutes).
`timescale 1ns/100ps
module rdt_zone_conv (
	// Source date and time
	input wire rdt_pkg::rdt_date_t in_date,
	input wire rdt_pkg::rdt_time_t in_time,
	// Signed shift in minutes
	input wire logic signed [15:0] offset,
	// Shifted date and time
	output rdt_pkg::rdt_date_t out_date,
	output rdt_pkg::rdt_time_t out_time
);

	logic [10:0] mod_in;
	logic signed [17:0] mod_sum;
	logic [10:0] mod_out;
	logic [1:0] step;
	logic [4:0] prev_len;

	// Minute of day moved by the offset, with day step
	always_comb begin
		mod_in = 11'(in_time.hour) * rdt_pkg::MIN_PER_HOUR +
			11'(in_time.minute);
		mod_sum = $signed({7'h00, mod_in}) +
			{{2{offset[15]}}, offset};
		step = 2'h0;
		mod_out = mod_sum[10:0];
		if (mod_sum < 0) begin
			mod_out = 11'(mod_sum + 18'(rdt_pkg::MIN_PER_DAY));
			step = 2'h2;
		end else if (mod_sum >= 18'(rdt_pkg::MIN_PER_DAY)) begin
			mod_out = 11'(mod_sum - 18'(rdt_pkg::MIN_PER_DAY));
			step = 2'h1;
		end
		out_time.hour = 5'(mod_out / rdt_pkg::MIN_PER_HOUR);
		out_time.minute = 6'(mod_out % rdt_pkg::MIN_PER_HOUR);
		out_time.second = in_time.second;
	end

	// Calendar roll forward or back by one day
	always_comb begin
		out_date = in_date;
		prev_len = rdt_pkg::month_len(
			(in_date.month == 4'h1) ? 4'hc : in_date.month - 4'h1,
			in_date.year);
		if (step == 2'h1) begin
			out_date.weekday = (in_date.weekday == 3'h7) ? 3'h1 :
				in_date.weekday + 3'h1;
			if (in_date.day >= rdt_pkg::month_len(in_date.month,
				in_date.year)) begin
				out_date.day = 5'h01;
				if (in_date.month == 4'hc) begin
					out_date.month = 4'h1;
					out_date.year = in_date.year + 12'h001;
				end else begin
					out_date.month = in_date.month + 4'h1;
				end
			end else begin
				out_date.day = in_date.day + 5'h01;
			end
		end else if (step == 2'h2) begin
			out_date.weekday = (in_date.weekday == 3'h1) ? 3'h7 :
				in_date.weekday - 3'h1;
			if (in_date.day == 5'h01) begin
				out_date.day = prev_len;
				if (in_date.month == 4'h1) begin
					out_date.month = 4'hc;
					out_date.year = in_date.year - 12'h001;
				end else begin
					out_date.month = in_date.month - 4'h1;
				end
			end else begin
				out_date.day = in_date.day - 5'h01;
			end
		end
	end

endmodule // rdt_zone_conv

// ===== hw/rdt_setter.sv
// Date, time and zone offset loader for the clock counter registers.
// Assumes an APB master on sys_clk; clock fields go out to the counter.
`timescale 1ns/100ps
module rdt_setter (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock counter fields
	output rdt_pkg::rdt_date_t clk_date,
	output rdt_pkg::rdt_time_t clk_time,
	// Operation done flags
	output logic [4:0] op_done
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [4:0] op_en, next_op_en;
	rdt_pkg::rdt_date_t date_in, next_date_in;
	rdt_pkg::rdt_time_t time_in, next_time_in;
	logic signed [15:0] zone_in, next_zone_in;
	logic signed [15:0] zone_off, next_zone_off;
	logic range_err, next_range_err;
	rdt_pkg::rdt_date_t next_clk_date, loc_date, next_loc_date;
	rdt_pkg::rdt_time_t next_clk_time, loc_time, next_loc_time;
	logic [4:0] next_op_done;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr_go, rd_sel, hit, date_good, time_good, local_good;
	rdt_pkg::rdt_date_t utc_date, rd_date, local_in_date;
	rdt_pkg::rdt_time_t utc_time, rd_time;

	// ****************************************************************
	// Zone converters
	// ****************************************************************
	// Local input widened to four digit year
	always_comb begin
		local_in_date = date_in;
		local_in_date.year = rdt_pkg::CENTURY_BASE + date_in.year;
	end

	// Local to UTC for loading
	rdt_zone_conv u_to_utc (
		.in_date(local_in_date),
		.in_time(time_in),
		.offset(-zone_off),
		.out_date(utc_date),
		.out_time(utc_time)
	);

	// UTC to local for reading back
	rdt_zone_conv u_to_local (
		.in_date(clk_date),
		.in_time(clk_time),
		.offset(zone_off),
		.out_date(rd_date),
		.out_time(rd_time)
	);

	// ****************************************************************
	// APB access
	// ****************************************************************
	// Decode and next bus answer
	always_comb begin
		wr_go = psel && penable && pready && pwrite;
		rd_sel = psel && penable && !pready;
		hit = 1'b1;
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			rdt_pkg::REG_CTRL: next_prdata = 32'(op_en);
			rdt_pkg::REG_DATE_IN: next_prdata = 32'(date_in);
			rdt_pkg::REG_TIME_IN: next_prdata = 32'(time_in);
			rdt_pkg::REG_ZONE_IN: next_prdata = 32'(unsigned'(zone_in));
			rdt_pkg::REG_STATUS:
				next_prdata = {23'h0, range_err, 3'h0, op_done};
			rdt_pkg::REG_CLK_DATE: next_prdata = 32'(clk_date);
			rdt_pkg::REG_CLK_TIME: next_prdata = 32'(clk_time);
			rdt_pkg::REG_LOC_DATE: next_prdata = 32'(loc_date);
			rdt_pkg::REG_LOC_TIME: next_prdata = 32'(loc_time);
			rdt_pkg::REG_ZONE: next_prdata = 32'(unsigned'(zone_off));
			default: hit = 1'b0;
		endcase
		// Data only with a read answer, zero otherwise
		if (!rd_sel || pwrite) begin
			next_prdata = 32'h0000_0000;
		end
		// One-cycle answer; clk_en low stretches it
		next_pready = rd_sel;
		next_pslverr = rd_sel && !hit;
	end

	// Bus answer registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// Software written registers and clock fields
	// ****************************************************************
	// Next values of controls, inputs, offset and clock fields
	always_comb begin
		next_op_en = op_en;
		next_date_in = date_in;
		next_time_in = time_in;
		next_zone_in = zone_in;
		next_zone_off = zone_off;
		next_range_err = range_err;
		next_clk_date = clk_date;
		next_clk_time = clk_time;
		next_loc_date = loc_date;
		next_loc_time = loc_time;
		// Range checks shared by the date, time and local loads
		date_good = rdt_pkg::date_ok(date_in);
		time_good = rdt_pkg::time_ok(time_in);
		local_good = date_good && time_good &&
			(date_in.year <= 12'h063);
		if (wr_go) begin
			unique case (paddr)
				rdt_pkg::REG_CTRL: next_op_en = pwdata[4:0];
				rdt_pkg::REG_DATE_IN:
					next_date_in = rdt_pkg::rdt_date_t'(pwdata[23:0]);
				rdt_pkg::REG_TIME_IN:
					next_time_in = rdt_pkg::rdt_time_t'(pwdata[16:0]);
				rdt_pkg::REG_ZONE_IN: next_zone_in = pwdata[15:0];
				rdt_pkg::REG_STATUS: if (pwdata[rdt_pkg::STAT_RANGE_ERR]) begin
					next_range_err = 1'b0;
				end
				default: ;
			endcase
		end
		// Plain date load, any year width, no conversion
		if (op_en[rdt_pkg::OP_DATE] && !op_en[rdt_pkg::OP_LOCAL]) begin
			if (date_good) begin
				next_clk_date = date_in;
			end else begin
				next_range_err = 1'b1;
			end
		end
		// Plain time load, no conversion
		if (op_en[rdt_pkg::OP_TIME] && !op_en[rdt_pkg::OP_LOCAL]) begin
			if (time_good) begin
				next_clk_time = time_in;
			end else begin
				next_range_err = 1'b1;
			end
		end
		// Local load stored as UTC, wins over plain loads
		if (op_en[rdt_pkg::OP_LOCAL]) begin
			if (local_good) begin
				next_clk_date = utc_date;
				next_clk_time = utc_time;
			end else begin
				next_range_err = 1'b1;
			end
		end
		// Zone offset load
		if (op_en[rdt_pkg::OP_ZONE]) begin
			next_zone_off = zone_in;
		end
		// Local read back
		if (op_en[rdt_pkg::OP_READ]) begin
			next_loc_date = rd_date;
			next_loc_time = rd_time;
		end
		// Done flags trail the enables by one edge
		next_op_done = op_en;
	end

	// Registers; the offset is cleared by every reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			op_en <= rdt_pkg::CTRL_RESET;
			date_in <= rdt_pkg::DATE_RESET;
			time_in <= rdt_pkg::TIME_RESET;
			zone_in <= rdt_pkg::ZONE_RESET;
			zone_off <= rdt_pkg::ZONE_RESET;
			range_err <= 1'b0;
			clk_date <= rdt_pkg::DATE_RESET;
			clk_time <= rdt_pkg::TIME_RESET;
			loc_date <= rdt_pkg::DATE_RESET;
			loc_time <= rdt_pkg::TIME_RESET;
			op_done <= 5'h00;
		end else if (clk_en) begin
			op_en <= next_op_en;
			date_in <= next_date_in;
			time_in <= next_time_in;
			zone_in <= next_zone_in;
			zone_off <= next_zone_off;
			range_err <= next_range_err;
			clk_date <= next_clk_date;
			clk_time <= next_clk_time;
			loc_date <= next_loc_date;
			loc_time <= next_loc_time;
			op_done <= next_op_done;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// Done flags
	a_done_follows_en: assert property (
		clk_en |=> op_done == $past(op_en))
		else $error("done flags do not follow enables");
	a_done_low_idle: assert property (
		clk_en && op_en == 5'h00 |=> op_done == 5'h00)
		else $error("done flag high while disabled");

	// Plain and local loads
	a_date_unchanged: assert property (
		clk_en && op_en[0] && !op_en[2] && date_good
		|=> clk_date == $past(date_in))
		else $error("date load altered fields");
	a_time_unchanged: assert property (
		clk_en && op_en[1] && !op_en[2] && time_good
		|=> clk_time == $past(time_in))
		else $error("time load altered fields");
	a_idle_clock_stable: assert property (
		(!clk_en || op_en[2:0] == 3'h0) |=> $stable(clk_date) &&
		$stable(clk_time))
		else $error("clock changed while no load enabled");
	a_local_to_utc: assert property (
		clk_en && op_en[2] && local_good
		|=> clk_time == $past(utc_time) && clk_date == $past(utc_date))
		else $error("local load not stored as UTC");

	// Zone offset load, hold and loss at reset
	a_zone_load: assert property (
		clk_en && op_en[3] ##1 clk_en && !op_en[3]
		|=> zone_off == $past(zone_in, 2))
		else $error("zone offset not loaded or not held");
	a_zone_volatile: assert property (
		@(posedge sys_clk) disable iff (1'b0)
		!rst_n |=> zone_off == rdt_pkg::ZONE_RESET)
		else $error("zone offset survived reset");

	// Error flag and read back
	a_bad_range_flag: assert property (
		clk_en && op_en[0] && !date_good |=> range_err)
		else $error("out of range date not flagged");
	a_read_local: assert property (
		clk_en && op_en[4] |=> loc_time == $past(rd_time))
		else $error("local read back not offset");

	// Bus answer
	a_apb_answer: assert property (
		clk_en && psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not one cycle");
	a_unmapped_err: assert property (
		clk_en && psel && penable && !pready && !hit |=> pslverr)
		else $error("unmapped address answered without error");
	a_mapped_no_err: assert property (
		clk_en && psel && penable && !pready && hit |=> !pslverr)
		else $error("mapped address answered with error");

	// Further load, error and freeze checks
	a_time_bad_flag: assert property (
		clk_en && op_en[1] && !time_good |=> range_err)
		else $error("out of range time not flagged");
	a_local_bad_flag: assert property (
		clk_en && op_en[2] && !local_good |=> range_err)
		else $error("out of range local input not flagged");
	a_read_date: assert property (
		clk_en && op_en[4] |=> loc_date == $past(rd_date))
		else $error("local date read back not offset");
	a_zone_held: assert property (
		clk_en && !op_en[3] |=> $stable(zone_off))
		else $error("zone offset changed while not enabled");
	a_error_sticky: assert property (
		range_err && !(clk_en && wr_go && paddr == rdt_pkg::REG_STATUS &&
		pwdata[rdt_pkg::STAT_RANGE_ERR]) |=> range_err)
		else $error("error flag dropped without a clear");
	a_frozen_state: assert property (
		!clk_en |=> $stable(op_done) && $stable(zone_off) &&
		$stable(pready))
		else $error("state moved while clock enable low");

	// Scenario covers
	c_local_load: cover property (clk_en && op_en[2] && local_good);
	c_day_wrap: cover property (clk_en && op_en[2] &&
		utc_date.day != local_in_date.day);
	c_zone_then_read: cover property (op_en[3] ##[1:20] op_en[4]);
	c_bad_input: cover property ($rose(range_err));
	c_clk_frozen: cover property (!clk_en && op_en != 5'h00);

endmodule // rdt_setter

// ===== sim/rdt_counter_model.sv
// Behavioural stand-in for the clock counter registers at the far side.
// Assumes the setter drives date and time fields registered on sys_clk.
`timescale 1ns/100ps
module rdt_counter_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Fields presented by the setter
	input wire rdt_pkg::rdt_date_t clk_date,
	input wire rdt_pkg::rdt_time_t clk_time,
	// Count of field values the counter cannot hold
	output int bad_count
);
	// Counter only holds in-range calendar and time fields
	initial bad_count = 0;
	always @(posedge sys_clk) begin
		if (rst_n && (clk_date.month < 4'h1 || clk_date.month > 4'hc ||
			clk_date.day < 5'h01 ||
			clk_date.weekday < 3'h1 ||
			clk_time.hour > 5'h17 || clk_time.minute > 6'h3b ||
			clk_time.second > 6'h3b)) begin
			bad_count++;
		end
	end
endmodule // rdt_counter_model

// ===== sim/rdt_setter_test.sv
// Self-checking bench of the date, time and zone offset setter.
// Assumes the design package is compiled first; APB master is this bench.
`timescale 1ns/100ps
module rdt_setter_test;
	logic sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] op_done;
	rdt_pkg::rdt_date_t clk_date;
	rdt_pkg::rdt_time_t clk_time;
	int fail_count, n_compared, cycles, bad_count;
	int i;
	logic [7:0] bad_a [8];
	logic [31:0] bad_d [8];
	logic [4:0] bad_op [8];

	// ****************************************************************
	// Design, far-side model, clock
	// ****************************************************************
	rdt_setter uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clk_date(clk_date), .clk_time(clk_time),
		.op_done(op_done));
	rdt_counter_model model (.sys_clk(sys_clk), .rst_n(rst_n),
		.clk_date(clk_date), .clk_time(clk_time), .bad_count(bad_count));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] dw(logic [11:0] y, logic [2:0] w,
		logic [4:0] d, logic [3:0] m);
		dw = {8'h00, y, w, d, m};
	endfunction
	function automatic logic [31:0] tw(logic [4:0] h, logic [5:0] m,
		logic [5:0] s);
		tw = {15'h0000, h, m, s};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; request held until pready seen at an edge
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Set operation enables, let load and done flag land
	task automatic run(input logic [4:0] ops);
		xfer(1'b1, rdt_pkg::REG_CTRL, {27'h0, ops});
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		chk(32'(clk_date), 32'(rdt_pkg::DATE_RESET));
		chk(32'(clk_time), 32'(rdt_pkg::TIME_RESET));
		chk(32'(op_done), 32'h0);
		xfer(1'b0, rdt_pkg::REG_ZONE, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_date;
		xfer(1'b1, rdt_pkg::REG_DATE_IN, dw(12'h019, 3'h7, 5'h1f, 4'hc));
		repeat (3) @(posedge sys_clk);
		chk(32'(clk_date), 32'(rdt_pkg::DATE_RESET));
		run(5'h01);
		chk(32'(clk_date), dw(12'h019, 3'h7, 5'h1f, 4'hc));
		chk(32'(op_done), 32'h01);
		xfer(1'b1, rdt_pkg::REG_DATE_IN, dw(12'h7ef, 3'h1, 5'h01, 4'h1));
		repeat (2) @(posedge sys_clk);
		chk(32'(clk_date), dw(12'h7ef, 3'h1, 5'h01, 4'h1));
		run(5'h00);
		chk(32'(op_done), 32'h0);
		xfer(1'b1, rdt_pkg::REG_DATE_IN, dw(12'h7d5, 3'h3, 5'h02, 4'h5));
		repeat (3) @(posedge sys_clk);
		chk(32'(clk_date), dw(12'h7ef, 3'h1, 5'h01, 4'h1));
		xfer(1'b1, rdt_pkg::REG_TIME_IN, tw(5'h17, 6'h3b, 6'h3b));
		run(5'h02);
		chk(32'(clk_time), tw(5'h17, 6'h3b, 6'h3b));
		chk(32'(op_done), 32'h02);
		run(5'h1b);
		chk(32'(op_done), 32'h1b);
		run(5'h00);
		chk(32'(clk_date), dw(12'h7d5, 3'h3, 5'h02, 4'h5));
		$display("test date and time done");
	endtask
	// Each bad field skips the load and sets the sticky error flag
	task automatic t_range;
		// Year case runs while the time input is still in range
		bad_a = '{rdt_pkg::REG_DATE_IN, rdt_pkg::REG_DATE_IN,
			rdt_pkg::REG_DATE_IN, rdt_pkg::REG_DATE_IN, rdt_pkg::REG_DATE_IN,
			rdt_pkg::REG_TIME_IN, rdt_pkg::REG_TIME_IN, rdt_pkg::REG_TIME_IN};
		bad_d = '{dw(12'h7d5, 3'h1, 5'h01, 4'h0),
			dw(12'h7d5, 3'h1, 5'h01, 4'hd), dw(12'h7d5, 3'h1, 5'h00, 4'h1),
			dw(12'h7d5, 3'h0, 5'h01, 4'h1), dw(12'h064, 3'h1, 5'h01, 4'h1),
			tw(5'h18, 6'h00, 6'h00), tw(5'h00, 6'h3c, 6'h00),
			tw(5'h00, 6'h00, 6'h3c)};
		bad_op = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h04, 5'h02, 5'h02, 5'h02};
		for (i = 0; i < 8; i++) begin
			xfer(1'b1, bad_a[i], bad_d[i]);
			run(bad_op[i]);
			chk(32'(clk_date), dw(12'h7d5, 3'h3, 5'h02, 4'h5));
			chk(32'(clk_time), tw(5'h17, 6'h3b, 6'h3b));
			chk(32'(op_done), 32'(bad_op[i]));
			run(5'h00);
			xfer(1'b0, rdt_pkg::REG_STATUS, 32'h0);
			chk(32'(rd[8]), 32'h1);
			xfer(1'b1, rdt_pkg::REG_STATUS, 32'h100);
			xfer(1'b0, rdt_pkg::REG_STATUS, 32'h0);
			chk(32'(rd[8]), 32'h0);
		end
		$display("test range done");
	endtask
	// Offset loaded at +60 and then -60 minutes, with local loads and read back
	task automatic t_local;
		xfer(1'b1, rdt_pkg::REG_ZONE_IN, 32'h3c);
		run(5'h08);
		run(5'h00);
		xfer(1'b0, rdt_pkg::REG_ZONE, 32'h0);
		chk(rd, 32'h3c);
		xfer(1'b1, rdt_pkg::REG_DATE_IN, dw(12'h018, 3'h7, 5'h0f, 4'h6));
		xfer(1'b1, rdt_pkg::REG_TIME_IN, tw(5'h0a, 6'h1e, 6'h2d));
		run(5'h04);
		chk(32'(clk_date), dw(12'h7e8, 3'h7, 5'h0f, 4'h6));
		chk(32'(clk_time), tw(5'h09, 6'h1e, 6'h2d));
		chk(32'(op_done), 32'h04);
		run(5'h10);
		run(5'h00);
		xfer(1'b0, rdt_pkg::REG_LOC_TIME, 32'h0);
		chk(rd, tw(5'h0a, 6'h1e, 6'h2d));
		xfer(1'b1, rdt_pkg::REG_ZONE_IN, 32'hffc4);
		run(5'h08);
		run(5'h00);
		xfer(1'b1, rdt_pkg::REG_DATE_IN, dw(12'h018, 3'h1, 5'h1e, 4'h6));
		xfer(1'b1, rdt_pkg::REG_TIME_IN, tw(5'h17, 6'h1e, 6'h00));
		run(5'h04);
		run(5'h00);
		chk(32'(clk_date), dw(12'h7e8, 3'h2, 5'h01, 4'h7));
		chk(32'(clk_time), tw(5'h00, 6'h1e, 6'h00));
		$display("test local done");
	endtask
	task automatic t_bus;
		xfer(1'b0, 8'h28, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		xfer(1'b1, rdt_pkg::REG_CLK_DATE, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk(32'(clk_date), dw(12'h7e8, 3'h2, 5'h01, 4'h7));
		chk(32'(bad_count), 32'h0);
		$display("test bus done");
	endtask
	// Clock enable freezes loads; a mid-run reset drops the offset
	task automatic t_restart;
		xfer(1'b1, rdt_pkg::REG_DATE_IN,
			dw(12'h7d1, 3'h4, 5'h09, 4'h3));
		run(5'h01);
		xfer(1'b1, rdt_pkg::REG_DATE_IN, dw(12'h7d2, 3'h5, 5'h0a, 4'h4));
		clk_en <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(32'(clk_date), dw(12'h7d1, 3'h4, 5'h09, 4'h3));
		chk(32'(op_done), 32'h01);
		clk_en <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(32'(clk_date), dw(12'h7d2, 3'h5, 5'h0a, 4'h4));
		xfer(1'b0, rdt_pkg::REG_ZONE, 32'h0);
		chk(rd, 32'h0000_ffc4);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk(32'(clk_date), 32'(rdt_pkg::DATE_RESET));
		chk(32'(op_done), 32'h0);
		xfer(1'b0, rdt_pkg::REG_ZONE, 32'h0);
		chk(rd, 32'h0);
		$display("test restart done");
	endtask

	// ****************************************************************
	// Main sequence and timeout
	// ****************************************************************
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		fail_count = 0;
		n_compared = 0;
		cycles = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_date();
		t_range();
		t_local();
		t_bus();
		t_restart();
		end_of_test();
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
endmodule // rdt_setter_test
